// ### common/twr_pkg.sv
// Package for the terminal watchdog, wake and reset-pulse unit.
// Assumes a 250 MHz system clock; all counts derive from it.
package twr_pkg;

  // System clock rate
  localparam int unsigned CLK_MHZ = 250;

  // Register indices (word index; byte address is four times the index)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_KEY = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CIRX = 4'h3;

  // Control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_RSS_BIT = 1;
  // Key register fields
  localparam int unsigned KEY_A_BIT = 1;
  localparam int unsigned KEY_B_BIT = 0;
  // Status register fields (wake, watchdog and code bits write one to clear)
  localparam int unsigned ST_WAKE_BIT = 0;
  localparam int unsigned ST_WDOG_BIT = 1;
  localparam int unsigned ST_CODE_BIT = 2;
  localparam int unsigned ST_PULSE_BIT = 3;
  localparam int unsigned ST_ENABLE_BIT = 4;

  // Reset values
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_RSS = 1'b0;
  localparam logic [3:0] RST_CODE = 4'hf;

  // Times in their own units
  localparam int unsigned WDOG_PERIOD_MS = 128;
  localparam int unsigned PULSE_WDOG_US = 125;
  localparam int unsigned PULSE_WAKE_MS = 16;

  // Cycle counts (longest time rounds down, least time rounds up; exact here)
  localparam int unsigned WDOG_CYCLES = WDOG_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned PULSE_WDOG_CYCLES = PULSE_WDOG_US * CLK_MHZ;
  localparam int unsigned PULSE_WAKE_CYCLES = PULSE_WAKE_MS * 1000 * CLK_MHZ;

  // Service sequence progress
  typedef enum logic [0:0] {
    KEY_IDLE = 1'b0,
    KEY_HALF = 1'b1
  } twr_key_t;

endpackage

// ### rtl/twr_sync.sv
// Two-flop synchroniser for asynchronous single-bit inputs.
// Assumes the input is a slow level from a pin.
`timescale 1ns/1ps
`default_nettype none
module twr_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic asyncIn, // Raw pin level
  output logic syncOut // Synchronised level
);
  logic stage1_ff;

  // First stage read only by second stage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage1_ff <= INIT;
      syncOut <= INIT;
    end else begin
      stage1_ff <= asyncIn;
      syncOut <= stage1_ff;
    end
  end
endmodule
`default_nettype wire

// ### rtl/twr_pulse_gen.sv
// Reset pulse generator: holds the reset pin for a chosen length.
// Assumes trigger pulses are one cycle wide and from the system clock.
`timescale 1ns/1ps
`default_nettype none
module twr_pulse_gen #(
  parameter int unsigned SHORT_CYCLES = twr_pkg::PULSE_WDOG_CYCLES,
  parameter int unsigned LONG_CYCLES = twr_pkg::PULSE_WAKE_CYCLES
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic trigShort, // Start short pulse
  input wire logic trigLong, // Start long pulse
  output logic pulseOut // Reset pin drive, high active
);
  localparam int CW = $clog2(LONG_CYCLES + 1);
  logic [CW-1:0] remain_ff;

  // Load length on trigger, count down otherwise; a pulse in progress completes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      remain_ff <= '0;
    end else if (trigLong) begin
      remain_ff <= CW'(LONG_CYCLES);
    end else if (trigShort && remain_ff < CW'(SHORT_CYCLES)) begin
      remain_ff <= CW'(SHORT_CYCLES);
    end else if (remain_ff != '0) begin
      remain_ff <= remain_ff - CW'(1);
    end
  end

  // Pin level from the triggers and the counter register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pulseOut <= 1'b0;
    end else begin
      pulseOut <= (trigLong || trigShort || remain_ff > CW'(1));
    end
  end
endmodule
`default_nettype wire

// ### rtl/twr_terminal_unit.sv
// Terminal support unit: watchdog, subscriber wake input, reset pulses.
// Assumes a host on a plain strobe port and the serial frame interface on pins.
//
// Summary of operation
// R1 - Unit is active only after software writes enable bit as one; code-change status and codeChangeIrq still set while disabled.
// R2 - When enabled, shared pin acts as wake input, not slot link data.
// R3 - Enable also unmasks wake and watchdog-overflow interrupt sources.
// R4 - Falling edge on wake input sets subscriber wake status.
// R5 - Host writes key 1,0 then 0,1 within 128 ms to service.
// R6 - Missing service within the period sets watchdog overflow status.
// R7 - Enable bit ignores clears; only hardware reset disables it.
// R8 - Select zero: wake edge or valid code change makes reset pulse.
// R9 - Select one: only watchdog expiry makes reset pulse.
// R10 - Wake falling edge pulls upstream serial data low to leave power-down.
// R11 - Wake or code-change reset also sets matching interrupt status.
// R12 - Watchdog counter halts in power-down without serial clock.
// R13 - Select bit does nothing unless unit is enabled.
// R14 - Host should set select to one while powered up.
// R15 - Any change of select clears and restarts the watchdog.
// R16 - Watchdog reset pulse lasts 125 us.
// R17 - Wake or code-change reset pulse lasts 16 ms.
// R18 - New code counts only when seen in two consecutive frames.
// R19 - Compared code is a four-bit field received once per frame.
// R20 - Out-of-sequence key write discards partial service progress.
// R21 - Hardware reset clears enable, watchdog and any reset pulse in progress.
`timescale 1ns/1ps
`default_nettype none
module twr_terminal_unit #(
  parameter int unsigned WDOG_CYCLES = twr_pkg::WDOG_CYCLES,
  parameter int unsigned PULSE_SHORT = twr_pkg::PULSE_WDOG_CYCLES,
  parameter int unsigned PULSE_LONG = twr_pkg::PULSE_WAKE_CYCLES
) (
  input wire logic clock, // System clock 250 MHz
  input wire logic sys_rst, // Async reset, high
  input wire logic [3:0] regAddr, // Register word index
  input wire logic [7:0] regWrData, // Write data
  input wire logic regWrStb, // Write strobe
  input wire logic regRdStb, // Read strobe
  output logic [7:0] regRdData, // Read data, cycle after strobe
  input wire logic sharedWakePin, // Shared wake pin, raw
  output logic slotLinkDataIn, // Pin level to slot link when not enabled
  input wire logic frameStb, // Frame strobe, same clock
  input wire logic [3:0] ciRxCode, // Received code, valid with frameStb
  input wire logic serialClockPresent, // High when serial clock runs
  output logic upstreamSerialDataLow, // Forces upstream data to zero
  output logic subscriberWakeIrq, // Wake status gated by enable
  output logic watchdogOverflowIrq, // Watchdog status gated by enable
  output logic codeChangeIrq, // Code-change status
  output logic resetPin // Reset output, high active
);
  localparam int WW = $clog2(WDOG_CYCLES + 1);

  typedef twr_pkg::twr_key_t twr_key_t;

  logic enable_ff;
  logic rss_ff;
  twr_key_t keyState_ff;
  logic [WW-1:0] wdog_ff;
  logic wakeSt_ff, wdogSt_ff, codeSt_ff;
  logic wakePrev_ff;
  logic [3:0] codeStable_ff, codeCand_ff;
  logic upLow_ff;
  logic wakeSync;
  logic wakeFall, codeChange, wdogExpire, serviceDone, rssWrite, rssChange;
  logic ctrlWr, keyWr, stWr;
  logic keyA, keyB;
  logic trigShort, trigLong, pulseNow;

  // Address decode helper
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    hit = (a == idx);
  endfunction

  assign ctrlWr = regWrStb && hit(regAddr, twr_pkg::ADDR_CTRL);
  assign keyWr = regWrStb && hit(regAddr, twr_pkg::ADDR_KEY);
  assign stWr = regWrStb && hit(regAddr, twr_pkg::ADDR_STATUS);
  assign keyA = regWrData[twr_pkg::KEY_A_BIT];
  assign keyB = regWrData[twr_pkg::KEY_B_BIT];

  // Pin synchroniser
  twr_sync #(.INIT(1'b1)) u_wakeSync (
    .clock(clock),
    .sys_rst(sys_rst),
    .asyncIn(sharedWakePin),
    .syncOut(wakeSync)
  );

  // R2 pin role
  assign slotLinkDataIn = enable_ff ? 1'b1 : wakeSync;

  // Edge detect on synchronised wake level
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wakePrev_ff <= 1'b1;
    end else begin
      wakePrev_ff <= wakeSync;
    end
  end
  // R4 falling edge
  assign wakeFall = enable_ff && wakePrev_ff && !wakeSync;

  // R1 R7 sticky enable
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      enable_ff <= twr_pkg::RST_ENABLE;
    end else if (ctrlWr && regWrData[twr_pkg::CTRL_ENABLE_BIT]) begin
      enable_ff <= 1'b1;
    end
  end

  // Reset source select
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rss_ff <= twr_pkg::RST_RSS;
    end else if (ctrlWr) begin
      rss_ff <= regWrData[twr_pkg::CTRL_RSS_BIT];
    end
  end
  assign rssWrite = ctrlWr && (regWrData[twr_pkg::CTRL_RSS_BIT] != rss_ff);
  // R15 select change
  assign rssChange = rssWrite;

  // R18 R19 double look on four-bit frame code
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      codeStable_ff <= twr_pkg::RST_CODE;
      codeCand_ff <= twr_pkg::RST_CODE;
    end else if (frameStb) begin
      codeCand_ff <= ciRxCode;
      if (ciRxCode == codeCand_ff) begin
        codeStable_ff <= ciRxCode;
      end
    end
  end
  assign codeChange = frameStb && (ciRxCode == codeCand_ff) && (ciRxCode != codeStable_ff);

  // R5 R20 service sequence
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      keyState_ff <= twr_pkg::KEY_IDLE;
    end else if (keyWr) begin
      if (keyA && !keyB) begin
        keyState_ff <= twr_pkg::KEY_HALF;
      end else begin
        keyState_ff <= twr_pkg::KEY_IDLE;
      end
    end
  end
  assign serviceDone = keyWr && (keyState_ff == twr_pkg::KEY_HALF) && !keyA && keyB;

  // R12 R15 R21 watchdog counter, halted in power-down
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wdog_ff <= '0;
    end else if (!enable_ff || serviceDone || rssChange || wdogExpire) begin
      wdog_ff <= '0;
    end else if (serialClockPresent) begin
      wdog_ff <= wdog_ff + WW'(1);
    end
  end
  // R6 expiry
  assign wdogExpire = enable_ff && serialClockPresent && (wdog_ff == WW'(WDOG_CYCLES - 1));

  // R4 R6 R11 sticky status, set wins over clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wakeSt_ff <= 1'b0;
      wdogSt_ff <= 1'b0;
      codeSt_ff <= 1'b0;
    end else begin
      wakeSt_ff <= wakeFall || (wakeSt_ff && !(stWr && regWrData[twr_pkg::ST_WAKE_BIT]));
      wdogSt_ff <= wdogExpire || (wdogSt_ff && !(stWr && regWrData[twr_pkg::ST_WDOG_BIT]));
      codeSt_ff <= codeChange || (codeSt_ff && !(stWr && regWrData[twr_pkg::ST_CODE_BIT]));
    end
  end

  // R3 sources unmasked by enable
  assign subscriberWakeIrq = enable_ff && wakeSt_ff;
  assign watchdogOverflowIrq = enable_ff && wdogSt_ff;
  assign codeChangeIrq = codeSt_ff;

  // R8 R9 R13 trigger selection
  assign trigLong = enable_ff && !rss_ff && (wakeFall || codeChange);
  assign trigShort = enable_ff && rss_ff && wdogExpire;

  // R16 R17 R21 pulse timing
  twr_pulse_gen #(
    .SHORT_CYCLES(PULSE_SHORT),
    .LONG_CYCLES(PULSE_LONG)
  ) u_pulse (
    .clock(clock),
    .sys_rst(sys_rst),
    .trigShort(trigShort),
    .trigLong(trigLong),
    .pulseOut(pulseNow)
  );
  assign resetPin = pulseNow;

  // R10 upstream data forced low until frames resume
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      upLow_ff <= 1'b0;
    end else if (wakeFall) begin
      upLow_ff <= 1'b1;
    end else if (serialClockPresent && frameStb) begin
      upLow_ff <= 1'b0;
    end
  end
  assign upstreamSerialDataLow = upLow_ff;

  // Read data, one cycle after strobe, zero otherwise and for unmapped
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regRdStb) begin
      unique case (regAddr)
        twr_pkg::ADDR_CTRL: regRdData <= {6'h00, rss_ff, enable_ff};
        twr_pkg::ADDR_KEY: regRdData <= {7'h00, keyState_ff == twr_pkg::KEY_HALF};
        twr_pkg::ADDR_STATUS: regRdData <= {3'h0, enable_ff, pulseNow, codeSt_ff, wdogSt_ff, wakeSt_ff};
        twr_pkg::ADDR_CIRX: regRdData <= {4'h0, codeStable_ff};
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### sim/twr_frame_src.sv
// Frame source model: frame strobe, received code, serial clock presence.
// Assumes one frame every 16 system clocks while the serial clock runs.
`timescale 1ns/1ps
`default_nettype none
module twr_frame_src (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Async reset, high
  input wire logic run, // Serial clock running
  input wire logic [3:0] code, // Code to send
  output logic frameStb, // Frame strobe
  output logic [3:0] ciRxCode, // Code, valid with strobe
  output logic serialClockPresent // Clock presence level
);
  logic [3:0] slotCnt_ff;
  assign serialClockPresent = run;
  // four-bit code once a frame, junk between frames
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slotCnt_ff <= 4'h0;
      frameStb <= 1'b0;
      ciRxCode <= 4'h0;
    end else begin
      slotCnt_ff <= run ? slotCnt_ff + 4'h1 : slotCnt_ff;
      frameStb <= run && slotCnt_ff == 4'hf;
      ciRxCode <= (run && slotCnt_ff == 4'hf) ? code : ~ciRxCode;
    end
  end
endmodule
`default_nettype wire

// ### sim/twr_terminal_unit_asserts.sv
// Checker for the terminal unit, bound to its ports.
// Assumes enable and select are only written through the control register.
`timescale 1ns/1ps
`default_nettype none
module twr_terminal_unit_chk #(
  parameter int unsigned PULSE_SHORT = 10,
  parameter int unsigned PULSE_LONG = 40
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Async reset
  input wire logic [3:0] regAddr, // Register index
  input wire logic [7:0] regWrData, // Write data
  input wire logic regWrStb, // Write strobe
  input wire logic regRdStb, // Read strobe
  input wire logic [7:0] regRdData, // Read data
  input wire logic sharedWakePin, // Wake pin
  input wire logic slotLinkDataIn, // Slot link level
  input wire logic upstreamSerialDataLow, // Upstream force
  input wire logic subscriberWakeIrq, // Wake irq
  input wire logic watchdogOverflowIrq, // Watchdog irq
  input wire logic codeChangeIrq, // Code irq
  input wire logic resetPin // Reset output
);
  logic enSeen_ff;
  logic rssSeen_ff;
  int unsigned hiCnt_ff;
  // Shadow of enable and select from host writes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      enSeen_ff <= 1'b0;
      rssSeen_ff <= 1'b0;
    end else if (regWrStb && regAddr == twr_pkg::ADDR_CTRL) begin
      enSeen_ff <= enSeen_ff | regWrData[twr_pkg::CTRL_ENABLE_BIT];
      rssSeen_ff <= regWrData[twr_pkg::CTRL_RSS_BIT];
    end
  end
  // Length of the current reset pulse
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hiCnt_ff <= 0;
    end else begin
      hiCnt_ff <= resetPin ? hiCnt_ff + 1 : 0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  idle_quiet_a: assert property (!enSeen_ff |-> !subscriberWakeIrq && !watchdogOverflowIrq && !resetPin)
    else $error("activity while disabled");
  pin_owner_a: assert property (enSeen_ff |-> slotLinkDataIn)
    else $error("slot link not parked");
  en_sticky_a: assert property (regRdStb && regAddr == twr_pkg::ADDR_STATUS && enSeen_ff |=> regRdData[4])
    else $error("enable lost");
  wake_status_a: assert property ($fell(sharedWakePin) && enSeen_ff |-> ##[2:5] subscriberWakeIrq)
    else $error("wake status missing");
  wake_upstream_a: assert property ($fell(sharedWakePin) && enSeen_ff |-> ##[2:5] upstreamSerialDataLow)
    else $error("upstream not forced");
  wdog_reset_a: assert property ($rose(watchdogOverflowIrq) && rssSeen_ff |-> ##[0:2] resetPin)
    else $error("no watchdog pulse");
  // only expiry pulses under select one
  wdog_cause_a: assert property ($rose(resetPin) && rssSeen_ff |-> ##[0:1] watchdogOverflowIrq)
    else $error("pulse without expiry");
  pulse_min_a: assert property ($fell(resetPin) |-> hiCnt_ff == PULSE_SHORT || hiCnt_ff >= PULSE_LONG)
    else $error("pulse too short");
  pulse_max_a: assert property (resetPin |-> hiCnt_ff <= PULSE_LONG + 2)
    else $error("pulse too long");
  long_pulse_c: cover property ($fell(resetPin) && hiCnt_ff > PULSE_SHORT + 2);
  code_change_c: cover property ($rose(codeChangeIrq));
  wdog_pulse_c: cover property ($rose(watchdogOverflowIrq) && rssSeen_ff);
endmodule
bind twr_terminal_unit twr_terminal_unit_chk #(.PULSE_SHORT(PULSE_SHORT), .PULSE_LONG(PULSE_LONG)) twr_chk_inst (
  .clock, .sys_rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .sharedWakePin, .slotLinkDataIn,
  .upstreamSerialDataLow, .subscriberWakeIrq, .watchdogOverflowIrq, .codeChangeIrq, .resetPin);
`default_nettype wire

// ### sim/tb_twr_terminal_unit.sv
// Testbench for the terminal unit: register tasks and pulse checks.
// Assumes shortened counts and the frame source model.
`timescale 1ns/1ps
`default_nettype none
module tb_twr_terminal_unit;
  localparam int unsigned PS = 10;
  localparam int unsigned PL = 40;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic sharedWakePin = 1'b1;
  logic run = 1'b1;
  logic [3:0] code = 4'hf;
  logic [7:0] rdData, regRdData;
  logic [3:0] ciRxCode;
  logic frameStb, serialClockPresent, slotLinkDataIn, upstreamSerialDataLow;
  logic subscriberWakeIrq, watchdogOverflowIrq, codeChangeIrq, resetPin;
  int fails = 0;
  int samples_checked = 0;
  always #2 clock = ~clock;
  twr_frame_src twr_frame_src_inst (.clock, .sys_rst, .run, .code, .frameStb, .ciRxCode, .serialClockPresent);
  twr_terminal_unit #(.WDOG_CYCLES(200), .PULSE_SHORT(PS), .PULSE_LONG(PL)) twr_terminal_unit_inst (
    .clock, .sys_rst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .sharedWakePin, .slotLinkDataIn,
    .frameStb, .ciRxCode, .serialClockPresent, .upstreamSerialDataLow, .subscriberWakeIrq,
    .watchdogOverflowIrq, .codeChangeIrq, .resetPin);
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register accesses, one idle cycle between them
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    @(negedge clock);
    rdData = regRdData;
  endtask
  task automatic frames(input int k);
    repeat (k) @(posedge clock iff frameStb);
  endtask
  // Wait for a reset pulse and check its length
  task automatic meas(input int unsigned exp);
    int unsigned n = 0;
    repeat (120) begin
      @(negedge clock);
      if (resetPin === 1'b1) break;
    end
    while (resetPin === 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk(8'(n), 8'(exp));
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd(twr_pkg::ADDR_STATUS);
    chk(rdData, 8'h00);
    rd(4'h7);
    chk(rdData, 8'h00);
    @(posedge clock) sharedWakePin <= 1'b0;
    repeat (60) @(posedge clock);
    chk(8'(slotLinkDataIn), 8'h00);
    chk(8'(resetPin), 8'h00);
    chk(8'(subscriberWakeIrq), 8'h00);
    @(posedge clock) sharedWakePin <= 1'b1;
    wr(twr_pkg::ADDR_CTRL, 8'h01);
    wr(twr_pkg::ADDR_CTRL, 8'h00);
    wr(twr_pkg::ADDR_STATUS, 8'h0f);
    rd(twr_pkg::ADDR_STATUS);
    chk(rdData & 8'h1d, 8'h10);
    chk(8'(slotLinkDataIn), 8'h01);
    @(posedge clock) sharedWakePin <= 1'b0;
    meas(PL);
    chk(8'(subscriberWakeIrq), 8'h01);
    @(posedge clock) sharedWakePin <= 1'b1;
    wr(twr_pkg::ADDR_STATUS, 8'h0f);
    frames(1);
    code <= 4'h5;
    frames(1);
    code <= 4'hf;
    frames(3);
    chk(8'(codeChangeIrq), 8'h00);
    code <= 4'h5;
    meas(PL);
    chk(8'(codeChangeIrq), 8'h01);
    wr(twr_pkg::ADDR_CTRL, 8'h03);
    wr(twr_pkg::ADDR_STATUS, 8'h0f);
    // Each select flip restarts the count, so no expiry
    repeat (150) @(posedge clock);
    wr(twr_pkg::ADDR_CTRL, 8'h01);
    repeat (150) @(posedge clock);
    wr(twr_pkg::ADDR_CTRL, 8'h03);
    repeat (3) begin
      repeat (140) @(posedge clock);
      wr(twr_pkg::ADDR_KEY, 8'h02);
      wr(twr_pkg::ADDR_KEY, 8'h01);
    end
    chk(8'(watchdogOverflowIrq), 8'h00);
    repeat (100) @(posedge clock);
    wr(twr_pkg::ADDR_KEY, 8'h02);
    wr(twr_pkg::ADDR_KEY, 8'h00);
    wr(twr_pkg::ADDR_KEY, 8'h01);
    meas(PS);
    chk(8'(watchdogOverflowIrq), 8'h01);
    wr(twr_pkg::ADDR_STATUS, 8'h0f);
    @(posedge clock) run <= 1'b0;
    repeat (150) @(posedge clock);
    // Wake in power-down under select one: no pulse, upstream forced low
    sharedWakePin <= 1'b0;
    repeat (10) @(posedge clock);
    chk(8'(resetPin), 8'h00);
    chk(8'(upstreamSerialDataLow), 8'h01);
    repeat (140) @(posedge clock);
    chk(8'(watchdogOverflowIrq), 8'h00);
    chk(8'(upstreamSerialDataLow), 8'h01);
    chk(8'(subscriberWakeIrq), 8'h01);
    @(posedge clock) run <= 1'b1;
    sharedWakePin <= 1'b1;
    repeat (100) @(posedge clock);
    chk(8'(upstreamSerialDataLow), 8'h00);
    meas(PS);
    // Mid-run hardware reset drops the enable
    @(posedge clock) sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd(twr_pkg::ADDR_CTRL);
    chk(rdData, 8'h00);
    summarize();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
